// ===== data_address_and_flag_unit.sv
// Operand address generation, pointer pairs and ALU flags with an AHB-Lite register port
//
// Summary of operation
// - Flag destination: flag-affecting ops drop result, update flags
// - Flag bits 7..5 read as zero
// - Negative flag copies result bit 7
// - Overflow flag on signed sign change
// - Zero flag set on zero result
// - Nibble carry from low nibble add
// - Carry from most significant bit
// - Subtract adds two's complement; borrow inverted
// - Rotates load nibble carry, carry from source
// - Access bit picks bank or access location
// - Access 60h+ maps to 060h/F80h regions
// - Move-between-files uses full address, ignores bank
// - Destination bit picks file or accumulator
// - Literal offset only when extended enabled
// - Branch carries 20-bit program address
// - Three 12-bit pointer pairs
// - Plain indirect: pointer address, pointer unchanged
// - Post change after use; pre increment before
// - Accumulator offset adds signed accumulator
// - Pointer steps carry across whole pair
// - Pointer steps leave flags untouched
// - Indirect to virtual operand: read 00h
// - Virtual write to own pair: no step (the step lands at resolve; a high-byte write keeps the stepped low byte)
//
// Added by the designer: the AHB-Lite interface to the registers and the address map.
module data_address_and_flag_unit
  import addr_flag_pkg::*;
#(
  parameter int PTR_W = 12  // Linear pointer width
) (
  // Clock and reset
  input  wire logic                     hclk,
  input  wire logic                     hresetn,
  // AHB-Lite slave
  input  wire logic                     hsel,
  input  wire logic [31:0]              haddr,
  input  wire logic [1:0]               htrans,
  input  wire logic                     hwrite,
  input  wire logic [2:0]               hsize,
  input  wire logic [31:0]              hwdata,
  input  wire logic                     hready,
  output logic      [31:0]              hrdata,
  output logic                          hreadyout,
  output logic                          hresp,
  // Decoder: address resolve request
  input  wire logic                     res_valid,
  input  wire logic [7:0]               res_field,
  input  wire logic                     res_access_sel,
  input  wire logic                     res_long,
  input  wire logic [11:0]              res_long_addr,
  input  wire logic [7:0]               acc_value,
  // Decoder: execute request
  input  wire logic                     exe_valid,
  input  wire addr_flag_pkg::alu_op_t   exe_op,
  input  wire logic [7:0]               exe_acc,
  input  wire logic [7:0]               exe_file,
  input  wire logic                     exe_dest_sel,
  input  wire logic [19:0]              exe_prog_field,
  // Data RAM and results
  output logic [11:0]                   ram_addr,
  output logic                          ram_addr_valid,
  output logic                          ram_read_zero,
  output logic                          ram_we,
  output logic [7:0]                    ram_wdata,
  output logic                          acc_we,
  output logic [7:0]                    acc_wdata,
  output logic                          prog_load,
  output logic [19:0]                   prog_target
);
  import addr_flag_pkg::*;

  localparam logic [11:0] VBASE [3] = '{VIRT_BASE0, VIRT_BASE1, VIRT_BASE2};

  // Architectural state
  logic [4:0]       flag_q;          // Implemented flags, negative down to carry
  logic [3:0]       bank_q;          // Bank select register
  logic [PTR_W-1:0] ptr_q [3];       // Pointer pairs
  logic             ext_en_q;        // Extended instruction enable
  // Bus state
  logic             bus_wr_q;        // Pending write data phase
  logic [7:0]       bus_ofs_q;       // Latched write offset
  logic [31:0]      hrdata_q;
  logic             hreadyout_q;
  logic             hresp_q;
  // Resolve and execute outputs
  logic [11:0]      ram_addr_q;
  logic             ram_addr_valid_q;
  logic             ram_read_zero_q;
  logic             ram_we_q;
  logic [7:0]       ram_wdata_q;
  logic             acc_we_q;
  logic [7:0]       acc_wdata_q;
  logic             prog_load_q;
  logic [19:0]      prog_target_q;

  // Bus decode
  logic bus_addr_ph;
  assign bus_addr_ph = hsel & hready & htrans[1];

  // Address phase: register read data and capture writes; zero wait, always OKAY
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bus_wr_q    <= 1'b0;
      bus_ofs_q   <= 8'h00;
      hrdata_q    <= 32'h0000_0000;
      hreadyout_q <= 1'b1;
      hresp_q     <= 1'b0;
    end else begin
      bus_wr_q    <= bus_addr_ph & hwrite;
      bus_ofs_q   <= haddr[7:0];
      hreadyout_q <= 1'b1;
      hresp_q     <= 1'b0;
      if (bus_addr_ph && !hwrite) begin
        case (haddr[7:0])
          FLAG_OFS: hrdata_q <= {27'h0, flag_q};
          BANK_OFS: hrdata_q <= {28'h0, bank_q};
          PTR0_OFS: hrdata_q <= {20'h0, 12'(ptr_q[0])};
          PTR1_OFS: hrdata_q <= {20'h0, 12'(ptr_q[1])};
          PTR2_OFS: hrdata_q <= {20'h0, 12'(ptr_q[2])};
          CFG_OFS:  hrdata_q <= {31'h0, ext_en_q};
          default:  hrdata_q <= 32'h0000_0000;               // Unmapped reads zero
        endcase
      end
    end
  end

  // Direct address formation
  logic [11:0] dir_addr;
  always_comb begin
    if (res_long) begin
      dir_addr = res_long_addr;
    end else if (res_access_sel) begin
      dir_addr = {bank_q, res_field};
    end else if (ext_en_q && res_field <= LIT_OFS_MAX) begin
      dir_addr = 12'(ptr_q[2]) + {4'h0, res_field};
    end else if (res_field >= ACC_HIGH) begin
      dir_addr = {BANK_TOP, res_field};
    end else begin
      dir_addr = {BANK_LOW, res_field};
    end
  end

  // Virtual operand decode: which pair and which kind
  logic        v_hit;
  logic [1:0]  v_pair;
  logic [11:0] v_kind;
  always_comb begin
    v_hit  = 1'b0;
    v_pair = 2'd0;
    v_kind = VK_PLAIN;
    for (int n = 0; n < 3; n++) begin
      if (dir_addr <= VBASE[n] && (VBASE[n] - dir_addr) <= VK_ACC_OFS) begin
        v_hit  = 1'b1;
        v_pair = 2'(n);
        v_kind = VBASE[n] - dir_addr;
      end
    end
  end

  // Indirect target and pointer step
  logic [11:0] ind_addr;
  logic [11:0] ptr_sel;
  logic [11:0] ptr_step;
  logic        ptr_change;
  logic        tgt_virtual;
  always_comb begin
    ptr_sel    = 12'(ptr_q[v_pair]);
    ptr_step   = ptr_sel;
    ptr_change = 1'b0;
    case (v_kind)
      VK_POST_INC: begin
        ind_addr   = ptr_sel;
        ptr_step   = ptr_sel + 12'h001;
        ptr_change = 1'b1;
      end
      VK_POST_DEC: begin
        ind_addr   = ptr_sel;
        ptr_step   = ptr_sel - 12'h001;
        ptr_change = 1'b1;
      end
      VK_PRE_INC: begin
        ind_addr   = ptr_sel + 12'h001;
        ptr_step   = ptr_sel + 12'h001;
        ptr_change = 1'b1;
      end
      VK_ACC_OFS: begin
        ind_addr = ptr_sel + {{4{acc_value[7]}}, acc_value};
      end
      default: begin
        ind_addr = ptr_sel;
      end
    endcase
    tgt_virtual = 1'b0;
    for (int n = 0; n < 3; n++) begin
      if (ind_addr <= VBASE[n] && (VBASE[n] - ind_addr) <= VK_ACC_OFS) begin
        tgt_virtual = 1'b1;
      end
    end
  end

  // Resolve stage: publish RAM address and whether a read must yield 00h
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ram_addr_q       <= 12'h000;
      ram_addr_valid_q <= 1'b0;
      ram_read_zero_q  <= 1'b0;
    end else begin
      ram_addr_valid_q <= res_valid;
      if (res_valid) begin
        ram_addr_q      <= v_hit ? ind_addr : dir_addr;
        ram_read_zero_q <= v_hit & tgt_virtual;
      end
    end
  end

  // ALU with flag generation
  logic [7:0] alu_res;
  logic [4:0] alu_flags;
  logic [4:0] alu_mask;     // Flags the operation affects
  logic [8:0] sum9;
  logic [4:0] sum5;
  always_comb begin
    sum9      = 9'h000;
    sum5      = 5'h00;
    alu_res   = 8'h00;
    alu_flags = flag_q;
    alu_mask  = 5'h00;
    case (exe_op)
      OP_ADD: begin
        sum9 = {1'b0, exe_file} + {1'b0, exe_acc};
        sum5 = {1'b0, exe_file[3:0]} + {1'b0, exe_acc[3:0]};
        alu_res = sum9[7:0];
        alu_flags[FLAG_C]   = sum9[8];
        alu_flags[FLAG_NIB] = sum5[4];
        alu_flags[FLAG_OVF] = (exe_file[7] == exe_acc[7]) &&
                              (sum9[7] != exe_file[7]);
        alu_mask = 5'h1F;
      end
      OP_SUB: begin
        // File minus accumulator by adding the two's complement
        sum9 = {1'b0, exe_file} + {1'b0, ~exe_acc} + 9'h001;
        sum5 = {1'b0, exe_file[3:0]} + {1'b0, ~exe_acc[3:0]} + 5'h01;
        alu_res = sum9[7:0];
        alu_flags[FLAG_C]   = sum9[8];
        alu_flags[FLAG_NIB] = sum5[4];
        alu_flags[FLAG_OVF] = (exe_file[7] != exe_acc[7]) &&
                              (sum9[7] != exe_file[7]);
        alu_mask = 5'h1F;
      end
      OP_AND: begin
        alu_res  = exe_file & exe_acc;
        alu_mask = 5'h14;
      end
      OP_OR: begin
        alu_res  = exe_file | exe_acc;
        alu_mask = 5'h14;
      end
      OP_XOR: begin
        alu_res  = exe_file ^ exe_acc;
        alu_mask = 5'h14;
      end
      OP_ROL: begin
        alu_res = {exe_file[6:0], flag_q[FLAG_C]};
        alu_flags[FLAG_C]   = exe_file[7];
        alu_flags[FLAG_NIB] = exe_file[3];
        alu_mask = 5'h17;
      end
      OP_ROR: begin
        alu_res = {flag_q[FLAG_C], exe_file[7:1]};
        alu_flags[FLAG_C]   = exe_file[0];
        alu_flags[FLAG_NIB] = exe_file[4];
        alu_mask = 5'h17;
      end
      OP_CLR: begin
        alu_res  = 8'h00;
        alu_mask = 5'h04;
      end
      OP_MOVE: begin
        alu_res = exe_file;
      end
      default: begin
        alu_res = 8'h00;
      end
    endcase
    alu_flags[FLAG_N] = alu_res[7];
    alu_flags[FLAG_Z] = (alu_res == 8'h00);
  end

  // Execute-stage destination decode
  logic file_dst;      // Result goes back to the file location
  logic to_flag_reg;   // File destination is the flag register
  logic wr_blocked;    // Target was a virtual operand
  logic is_alu;
  assign is_alu      = (exe_op != OP_NONE) && (exe_op != OP_BRANCH);
  assign file_dst    = exe_valid && is_alu && exe_dest_sel;
  assign to_flag_reg = file_dst && (ram_addr_q == FLAG_SFR_ADDR);
  assign wr_blocked  = ram_read_zero_q;

  // Pointer byte hit by a file write: returns pair and which byte
  logic       ptr_wr_hit;
  logic [1:0] ptr_wr_pair;
  logic       ptr_wr_high;
  always_comb begin
    ptr_wr_hit  = 1'b0;
    ptr_wr_pair = 2'd0;
    ptr_wr_high = 1'b0;
    for (int n = 0; n < 3; n++) begin
      if (ram_addr_q == VBASE[n] - VK_HIGH || ram_addr_q == VBASE[n] - VK_LOW) begin
        ptr_wr_hit  = file_dst && !wr_blocked;
        ptr_wr_pair = 2'(n);
        ptr_wr_high = (ram_addr_q == VBASE[n] - VK_HIGH);
      end
    end
  end

  // Execute stage: RAM write, accumulator write and branch target
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ram_we_q      <= 1'b0;
      ram_wdata_q   <= 8'h00;
      acc_we_q      <= 1'b0;
      acc_wdata_q   <= 8'h00;
      prog_load_q   <= 1'b0;
      prog_target_q <= 20'h00000;
    end else begin
      // Flag-affecting result aimed at the flag register is discarded
      ram_we_q    <= file_dst && !wr_blocked && !ptr_wr_hit &&
                     !(to_flag_reg && alu_mask != 5'h00);
      ram_wdata_q <= alu_res;
      acc_we_q    <= exe_valid && is_alu && !exe_dest_sel;
      acc_wdata_q <= alu_res;
      prog_load_q <= exe_valid && (exe_op == OP_BRANCH);
      if (exe_valid && exe_op == OP_BRANCH) begin
        prog_target_q <= exe_prog_field;
      end
    end
  end

  // Flag register: core update wins over a bus write in the same cycle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      flag_q <= FLAG_RST;
    end else if (exe_valid && is_alu && alu_mask != 5'h00) begin
      flag_q <= (alu_flags & alu_mask) | (flag_q & ~alu_mask);
    end else if (to_flag_reg && !wr_blocked) begin
      flag_q <= alu_res[FLAG_W-1:0];
    end else if (bus_wr_q && bus_ofs_q == FLAG_OFS) begin
      flag_q <= hwdata[FLAG_W-1:0];
    end
  end

  // Bank select and configuration
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bank_q   <= BANK_RST;
      ext_en_q <= 1'b0;
    end else if (bus_wr_q) begin
      if (bus_ofs_q == BANK_OFS) begin
        bank_q <= hwdata[3:0];
      end
      if (bus_ofs_q == CFG_OFS) begin
        ext_en_q <= hwdata[0];
      end
    end
  end

  // Pointer pairs: file write beats bus write beats automatic step
  for (genvar g = 0; g < 3; g++) begin : g_ptr
    logic bus_hit;
    assign bus_hit = bus_wr_q && (bus_ofs_q == PTR0_OFS + 8'(4 * g));
    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        ptr_q[g] <= PTR_RST;
      end else if (ptr_wr_hit && ptr_wr_pair == 2'(g)) begin
        // Written value stands with no step applied
        if (ptr_wr_high) begin
          ptr_q[g] <= {alu_res[3:0], ptr_q[g][7:0]};
        end else begin
          ptr_q[g] <= {ptr_q[g][11:8], alu_res};
        end
      end else if (bus_hit) begin
        ptr_q[g] <= hwdata[PTR_W-1:0];
      end else if (res_valid && v_hit && ptr_change && v_pair == 2'(g)) begin
        ptr_q[g] <= ptr_step;
      end
    end
  end

  // Outputs straight from flops
  assign hrdata         = hrdata_q;
  assign hreadyout      = hreadyout_q;
  assign hresp          = hresp_q;
  assign ram_addr       = ram_addr_q;
  assign ram_addr_valid = ram_addr_valid_q;
  assign ram_read_zero  = ram_read_zero_q;
  assign ram_we         = ram_we_q;
  assign ram_wdata      = ram_wdata_q;
  assign acc_we         = acc_we_q;
  assign acc_wdata      = acc_wdata_q;
  assign prog_load      = prog_load_q;
  assign prog_target    = prog_target_q;

  // Checks
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  flag_dest_drop_a: assert property (exe_valid && (exe_op == OP_ADD) && to_flag_reg |=>
    !ram_we) else $error("result written to flag register");
  flag_neg_a: assert property (exe_valid && (exe_op == OP_ADD) && !to_flag_reg |=>
    flag_q[FLAG_N] == acc_wdata_q[7] || !acc_we_q) else $error("negative flag wrong");
  flag_zero_a: assert property (acc_we_q && $past(alu_mask[FLAG_Z]) && !$past(to_flag_reg) |->
    flag_q[FLAG_Z] == (acc_wdata_q == 8'h00)) else $error("zero flag wrong");
  sub_carry_a: assert property (exe_valid && exe_op == OP_SUB |=>
    flag_q[FLAG_C] == ($past(exe_file) >= $past(exe_acc))) else $error("borrow polarity");
  add_carry_a: assert property (exe_valid && exe_op == OP_ADD |=>
    flag_q[FLAG_C] == ((9'($past(exe_file)) + 9'($past(exe_acc))) > 9'h0FF))
    else $error("add carry wrong");
  bank_addr_a: assert property (res_valid && !res_long && res_access_sel && !v_hit |=>
    ram_addr == {$past(bank_q), $past(res_field)}) else $error("bank address wrong");
  post_inc_step_a: assert property (res_valid && v_hit && v_kind == VK_POST_INC &&
    !bus_wr_q && !ptr_wr_hit |=> ram_addr == $past(ptr_sel) &&
    12'(ptr_q[$past(v_pair)]) == $past(ptr_sel) + 12'h001) else $error("post step wrong");
  step_flags_a: assert property (res_valid && !exe_valid && !bus_wr_q |=>
    $stable(flag_q)) else $error("pointer step touched flags");
  virt_zero_a: assert property (ram_read_zero_q && file_dst |=>
    !ram_we) else $error("write to virtual operand");
  reserved_a: assert property (bus_addr_ph && !hwrite && haddr[7:0] == FLAG_OFS |=>
    hrdata[7:5] == 3'b000) else $error("reserved flag bits nonzero");

  post_inc_c: cover property (res_valid && v_hit && v_kind == VK_POST_INC);
  sub_c:     cover property (exe_valid && exe_op == OP_SUB ##1 !flag_q[FLAG_C]);
  flag_dst_c: cover property (exe_valid && to_flag_reg);
  virt_c:    cover property (ram_read_zero_q);

endmodule

// ===== addr_flag_pkg.sv
// Constants, offsets and types for the data address and flag unit
package addr_flag_pkg;

  // Bus register byte offsets
  localparam logic [7:0] FLAG_OFS   = 8'h00;  // ALU flag register
  localparam logic [7:0] BANK_OFS   = 8'h04;  // Bank select register
  localparam logic [7:0] PTR0_OFS   = 8'h08;  // Pointer pair zero
  localparam logic [7:0] PTR1_OFS   = 8'h0C;  // Pointer pair one
  localparam logic [7:0] PTR2_OFS   = 8'h10;  // Pointer pair two
  localparam logic [7:0] CFG_OFS    = 8'h14;  // Configuration (extended enable)

  // Flag register field positions
  localparam int FLAG_C   = 0;  // Carry / inverted borrow
  localparam int FLAG_NIB = 1;  // Nibble carry
  localparam int FLAG_Z   = 2;  // Zero
  localparam int FLAG_OVF = 3;  // Signed overflow
  localparam int FLAG_N   = 4;  // Negative
  localparam int FLAG_W   = 5;  // Implemented flag width

  // Reset values
  localparam logic [4:0]  FLAG_RST = 5'h00;
  localparam logic [3:0]  BANK_RST = 4'h0;
  localparam logic [11:0] PTR_RST  = 12'h000;

  // Data space map
  localparam logic [11:0] FLAG_SFR_ADDR = 12'hFD8;  // Flag register in data space
  localparam logic [7:0]  ACC_SPLIT     = 8'h60;    // First access location above low part
  localparam logic [7:0]  ACC_HIGH      = 8'h80;    // First access location in top bank
  localparam logic [7:0]  LIT_OFS_MAX   = 8'h5F;    // Largest literal offset
  localparam logic [3:0]  BANK_LOW      = 4'h0;
  localparam logic [3:0]  BANK_TOP      = 4'hF;

  // Virtual operand block of each pair: base is the plain operand, then downward
  localparam logic [11:0] VIRT_BASE0 = 12'hFEF;
  localparam logic [11:0] VIRT_BASE1 = 12'hFE7;
  localparam logic [11:0] VIRT_BASE2 = 12'hFDF;
  localparam logic [11:0] VK_PLAIN   = 12'h000;  // Plain indirect operand
  localparam logic [11:0] VK_POST_INC = 12'h001;  // Post-increment operand
  localparam logic [11:0] VK_POST_DEC = 12'h002;  // Post-decrement operand
  localparam logic [11:0] VK_PRE_INC  = 12'h003;  // Pre-increment operand
  localparam logic [11:0] VK_ACC_OFS  = 12'h004;  // Accumulator-offset operand
  localparam logic [11:0] VK_HIGH    = 12'h005;  // Pointer high byte register
  localparam logic [11:0] VK_LOW     = 12'h006;  // Pointer low byte register

  // ALU operations issued by the decoder
  typedef enum logic [3:0] {
    OP_NONE, OP_ADD, OP_SUB, OP_AND, OP_OR, OP_XOR,
    OP_ROL, OP_ROR, OP_CLR, OP_MOVE, OP_BRANCH
  } alu_op_t;

endpackage

// ===== ram_model.sv
// Behavioural data RAM standing beyond the address unit
module ram_model (
  // Clock
  input  wire logic        hclk,
  // Access from the unit
  input  wire logic [11:0] ram_addr,
  input  wire logic        ram_read_zero,
  input  wire logic        ram_we,
  input  wire logic [7:0]  ram_wdata,
  // Read data back towards the decoder
  output logic      [7:0]  rdata
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [7:0] mem [4096];  // Byte storage, unknown until written

  // Store strobed writes at the resolved address
  always @(posedge hclk) begin
    if (ram_we) begin
      mem[ram_addr] <= ram_wdata;
    end
  end

  // A virtual target reads as zero, never as stale memory
  assign rdata = ram_read_zero ? 8'h00 : mem[ram_addr];
endmodule

// ===== data_address_and_flag_unit_tb.sv
// Self-checking bench for the data address and flag unit
module data_address_and_flag_unit_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import addr_flag_pkg::*;

  // Bus side
  logic        hclk, hreadyout, hresp, hresetn = 1'b0, hsel = 1'b1, hwrite = 1'b0;
  logic [1:0]  htrans = 2'h0;
  logic [2:0]  hsize  = 3'h2;
  logic [31:0] hrdata, haddr = '0, hwdata = '0;
  // Decoder side
  logic        res_valid = 1'b0, res_access_sel = 1'b0, res_long = 1'b0;
  logic        exe_valid = 1'b0, exe_dest_sel = 1'b0;
  logic [7:0]  res_field = '0, acc_value = 8'hFE, exe_acc = '0, exe_file = '0;
  logic [11:0] res_long_addr = '0;
  logic [19:0] exe_prog_field = 20'hABCDE;
  alu_op_t     exe_op = OP_NONE;
  // Unit outputs and RAM read data
  logic [11:0] ram_addr;
  logic        ram_addr_valid, ram_read_zero, ram_we, acc_we, prog_load;
  logic [7:0]  ram_wdata, acc_wdata, rdata;
  logic [19:0] prog_target;
  int          mismatches = 0, checked = 0;

  data_address_and_flag_unit dut (.hready(hreadyout), .*);
  ram_model ram (.*);

  // Free-running clock, 8 ns period
  initial begin
    hclk = 1'b0;
    forever #4 hclk = ~hclk;
  end

  // Compare and count
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  // Verdict and end of run
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // Wait for the ready edge, bounded
  task automatic rdy;
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 50);
    if (n >= 50) begin
      mismatches++;
      end_of_test;
    end
  endtask

  // One single AHB-Lite transfer; reads compare masked data
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic [31:0] e, input logic [31:0] m = 32'hFFFF_FFFF);
    @(posedge hclk);
    haddr  <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    rdy;
    htrans <= 2'h0;
    hwdata <= d;
    rdy;
    if (!w) chk(hrdata & m, e);
    chk({hreadyout, hresp}, 2'b10);
  endtask

  // Resolve an operand and check the address handed to RAM
  task automatic rs(input logic l, input logic [7:0] f, input logic s, input logic [11:0] e);
    @(posedge hclk);
    res_valid      <= 1'b1;
    res_long       <= l;
    res_long_addr  <= e;
    res_field      <= f;
    res_access_sel <= s;
    @(posedge hclk);
    res_valid <= 1'b0;
    #1;
    chk({ram_addr_valid, ram_addr}, {1'b1, e});
  endtask

  // Issue one execute request and let its results land
  task automatic ex(input alu_op_t op, input logic [7:0] a, input logic [7:0] f, input logic d);
    @(posedge hclk);
    exe_valid    <= 1'b1;
    exe_op       <= op;
    exe_acc      <= a;
    exe_file     <= f;
    exe_dest_sel <= d;
    @(posedge hclk);
    exe_valid <= 1'b0;
    #1;
  endtask

  // Flag reset value, unimplemented flag bits, unmapped offset
  task automatic t_regs;
    bus(0, FLAG_OFS, 0, 0);
    bus(1, FLAG_OFS, 32'hFF, 0);
    bus(0, FLAG_OFS, 0, 32'h1F);
    bus(0, 8'h40, 0, 0);
    $display("register test done");
  endtask

  // Direct, access, literal offset and full address forms
  task automatic t_addr;
    bus(1, BANK_OFS, 3, 0);
    rs(0, 8'h45, 1, 12'h345);
    rs(0, 8'h70, 0, 12'h070);
    rs(0, 8'h90, 0, 12'hF90);
    rs(0, 8'h20, 0, 12'h020);
    bus(1, PTR2_OFS, 32'h200, 0);
    bus(1, CFG_OFS, 1, 0);
    rs(0, 8'h20, 0, 12'h220);
    bus(1, CFG_OFS, 0, 0);
    rs(1, 8'h45, 1, 12'h123);
    $display("address test done");
  endtask

  // Arithmetic flags, destinations, rotates and branch
  task automatic t_alu;
    alu_op_t     op [10] = '{OP_ADD, OP_ADD, OP_ADD, OP_SUB, OP_SUB, OP_AND, OP_SUB,
                             OP_OR, OP_XOR, OP_CLR};
    logic [31:0] t  [10] = '{32'h8080_000D, 32'h010F_1002, 32'h017F_801A, 32'h0605_FF10,
                             32'h0505_0007, 32'h8081_8013, 32'h0180_7F09, 32'h0000_000D,
                             32'hFF0F_F019, 32'h1234_001D};
    for (int i = 0; i < 10; i++) begin
      ex(op[i], t[i][31:24], t[i][23:16], 1'b0);
      chk({acc_we, acc_wdata}, {1'b1, t[i][15:8]});
      bus(0, FLAG_OFS, 0, {24'h0, t[i][7:0]});
    end
    ex(OP_ROL, 8'h00, 8'h88, 1'b0);
    bus(0, FLAG_OFS, 0, 32'h3, 32'h3);
    ex(OP_ROR, 8'h00, 8'h10, 1'b0);
    bus(0, FLAG_OFS, 0, 32'h2, 32'h3);
    rs(1, 8'h00, 0, 12'h050);
    ex(OP_ADD, 8'h01, 8'h02, 1'b1);
    chk({ram_we, ram_wdata, acc_we}, {1'b1, 8'h03, 1'b0});
    @(posedge hclk);
    #1;
    chk(rdata, 8'h03);
    rs(1, 8'h00, 0, FLAG_SFR_ADDR);
    ex(OP_ADD, 8'h80, 8'h80, 1'b1);
    chk(ram_we, 1'b0);
    bus(0, FLAG_OFS, 0, 32'h0D);
    ex(OP_BRANCH, 8'h00, 8'h00, 1'b0);
    chk({prog_load, prog_target}, {1'b1, 20'hABCDE});
    $display("flag test done");
  endtask

  // Pointer operands across a low-byte roll-over, then a virtual target
  task automatic t_ptr;
    logic [11:0] ad [5] = '{12'h0FF, 12'h100, 12'h100, 12'h100, 12'h0FE};
    logic [11:0] pv [5] = '{12'h100, 12'h0FF, 12'h100, 12'h100, 12'h100};
    logic [7:0]  fl [5] = '{8'hEE, 8'hED, 8'hEC, 8'hEF, 8'hEB};
    bus(1, PTR0_OFS, 32'h0FF, 0);
    bus(1, FLAG_OFS, 32'h1F, 0);
    for (int i = 0; i < 5; i++) begin
      rs(0, fl[i], 0, ad[i]);
      bus(0, PTR0_OFS, 0, {20'h0, pv[i]});
    end
    bus(0, FLAG_OFS, 0, 32'h1F);
    bus(1, PTR0_OFS, 32'hFE7, 0);
    rs(0, 8'hEF, 0, 12'hFE7);
    chk(ram_read_zero, 1'b1);
    ex(OP_ADD, 8'h01, 8'h02, 1'b1);
    chk({ram_we, rdata}, {1'b0, 8'h00});
    bus(1, PTR0_OFS, 32'hFE9, 0);
    rs(0, 8'hEE, 0, 12'hFE9);
    ex(OP_MOVE, 8'h00, 8'h34, 1'b1);
    bus(0, PTR0_OFS, 0, 32'hF34);
    $display("pointer test done");
  endtask

  // Main sequence
  initial begin
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    t_regs;
    t_addr;
    t_alu;
    t_ptr;
    end_of_test;
  end
endmodule
